// ==== include/epwp_pkg.sv ====
/*
 * Shared constants and types of the page-write and write-protection host
 * controller for a four-lane parallel EEPROM module.
 * Assumes a single 50 MHz system clock and a device whose strobes are
 * active low and whose four byte lanes are independent 128K-byte blocks.
 */
package epwp_pkg;

	localparam int CLK_NS    = 20;
	localparam int T_WP_NS   = 100;
	localparam int T_WPH_NS  = 50;
	localparam int T_BLC_US  = 150;
	localparam int T_WC_MS   = 10;
	localparam int T_LOCK_MS = 5;

	localparam int NS_PER_US = 1000;
	localparam int NS_PER_MS = 1000000;

	// Least times round up, the byte load window is a longest time.
	localparam int CYC_WP   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_WPH  = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_BLC  = (T_BLC_US * NS_PER_US) / CLK_NS;
	localparam int CYC_WC   = (T_WC_MS * NS_PER_MS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_LOCK = (T_LOCK_MS * NS_PER_MS + CLK_NS - 1) / CLK_NS;

	// Slack kept between our own load spacing and the device window.
	localparam int CYC_GAP_MARGIN = 4 * (CYC_WP + CYC_WPH + 2);

	localparam int TMR_W      = 20;
	localparam int ADDR_W     = 17;
	localparam int DATA_W     = 32;
	localparam int LANES      = 4;
	localparam int PAGE_LSB   = 7;
	localparam int SEQ_W      = 3;
	localparam int CNT_W      = 8;

	localparam logic [CNT_W-1:0] PAGE_BYTES  = 8'h80;
	localparam logic [SEQ_W-1:0] SEQ_ON_LEN  = 3'h3;
	localparam logic [SEQ_W-1:0] SEQ_OFF_LEN = 3'h6;
	localparam logic [SEQ_W-1:0] SEQ_ON_IDX  = 3'h2;
	localparam logic [SEQ_W-1:0] SEQ_NONE    = 3'h0;
	localparam logic [7:0]       SEQ_ON_CODE = 8'ha0;

	localparam logic [ADDR_W-1:0] SEQ_ADDR [0:5] = '{
		17'h05555, 17'h02aaa, 17'h05555, 17'h05555, 17'h02aaa, 17'h05555};
	localparam logic [7:0] SEQ_OFF_DATA [0:5] = '{
		8'haa, 8'h55, 8'h80, 8'haa, 8'h55, 8'h20};

	localparam logic [LANES-1:0] LANES_OFF = 4'hf;

	typedef enum logic [1:0] {
		OP_PLAIN    = 2'h0,
		OP_SDP_WR   = 2'h1,
		OP_SDP_OFF  = 2'h2
	} epwp_op_t;

	typedef struct packed {
		epwp_op_t         op;
		logic [LANES-1:0] lanes;
		logic             has_data;
	} epwp_cmd_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              last;
	} epwp_word_t;

	typedef enum logic [7:0] {
		S_LOCK  = 8'h01,
		S_IDLE  = 8'h02,
		S_NEXT  = 8'h04,
		S_SETUP = 8'h08,
		S_PULSE = 8'h10,
		S_HOLD  = 8'h20,
		S_WAITW = 8'h40,
		S_PROG  = 8'h80
	} epwp_state_t;

endpackage

// ==== verification/epwp_dev.sv ====
/* Behavioural model of the four-lane EEPROM that the host drives.
 * Assumes its pins are sampled on the host clock. */
`timescale 1ns/1ps
module epwp_dev #(
	parameter int BLC  = 200,
	parameter int WC   = 40,
	parameter int LOCK = 20
) (
	input  wire logic        clk_sys,
	input  wire logic [16:0] addr,
	input  wire logic [31:0] dq,
	input  wire logic [3:0]  cs_n,
	input  wire logic [3:0]  we_n,
	input  wire logic        oe_n
);
	logic [3:0]   prot = 4'h0;
	logic [7:0]   mem [0:3][0:511] = '{default: 8'hff};
	logic [7:0]   pb [0:3][0:127];
	logic [127:0] pv [0:3] = '{default: '0};
	logic [16:0]  al [0:3];
	logic [9:0]   pg [0:3];
	logic [3:0]   lo = 4'h0, opn = 4'h0, on = 4'h0, off = 4'h0, unl = 4'h0;
	logic [3:0]   tog = 4'h0;
	logic [7:0]   lastb [0:3] = '{default: 8'hff};
	logic [7:0]   rd [0:3];
	int           blc [0:3] = '{default: 0};
	int           prog [0:3] = '{default: 0};
	int           st [0:3] = '{default: 0};
	int           up = 0, viol = 0;
	logic         w;
	localparam logic [16:0] SA [0:5] = '{17'h05555, 17'h02aaa, 17'h05555,
		17'h05555, 17'h02aaa, 17'h05555};
	localparam logic [7:0] SD [0:5] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55,
		8'h20};
	task load(input int l);
		if (st[l] == 2 && al[l] == 17'h05555 && dq[7:0] == 8'ha0) begin
			unl[l] = 1'b1;
			on[l] = 1'b1;
			st[l] = 7;
		end else if (st[l] < 6 && al[l] == SA[st[l]]
				&& dq[7:0] == SD[st[l]]) begin
			st[l]++;
			off[l] = st[l] == 6;
		end else begin
			// Data page fixed; command bytes sit on other pages.
			if (opn[l] && al[l][16:7] != pg[l])
				viol++;
			opn[l] = 1'b1;
			pb[l][al[l][6:0]] = dq[8*l+:8];
			pv[l][al[l][6:0]] = 1'b1;
			lastb[l] = dq[8*l+:8];
			st[l] = 7;
		end
		pg[l] = al[l][16:7];
	endtask
	always @(posedge clk_sys) begin
		up++;
		for (int l = 0; l < 4; l++) begin
			// Write needs select and strobe low.
			// Sampling on the clock drops glitches far shorter than a period.
			w = !cs_n[l] && !we_n[l] && oe_n;
			if (prog[l] > 0 && (w || addr[16:7] != pg[l]))
				viol++;
			// No loads in lockout or programming.
			if (up > LOCK && prog[l] == 0) begin
				if (w && !lo[l]) begin
					al[l] = addr;
					blc[l] = BLC;
				end
				if (!w && lo[l])
					load(l);
			end
			lo[l] = w;
			// Status returned to a read while programming.
			if (!cs_n[l] && !oe_n)
				tog[l] = ~tog[l];
			rd[l] = (prog[l] > 0) ?
				{~lastb[l][7], tog[l], lastb[l][5:0]} : lastb[l];
			if (prog[l] > 0) begin
				prog[l]--;
				// Protection changes at end of write.
				if (prog[l] == 0) begin
					prot[l] = on[l] | (prot[l] & !off[l]);
					on[l] = 1'b0;
					off[l] = 1'b0;
					unl[l] = 1'b0;
				end
			end else if (blc[l] > 0) begin
				blc[l]--;
				if (blc[l] == 0) begin
					for (int i = 0; i < 128; i++)
						if (pv[l][i] && (!prot[l] || unl[l]))
							mem[l][{pg[l][1:0], i[6:0]}] = pb[l][i];
					pv[l] = '0;
					opn[l] = 1'b0;
					st[l] = 0;
					prog[l] = WC;
				end
			end
		end
	end
endmodule // epwp_dev

// ==== verification/epwp_host_tb.sv ====
/* Self-checking bench of the EEPROM host controller.
 * Assumes the package and the device model are compiled first. */
`timescale 1ns/1ps
module epwp_host_tb import epwp_pkg::*;;
	logic              clk_sys = 1'b0, srst = 1'b1;
	logic              cmd_valid = 1'b0, wr_valid = 1'b0;
	epwp_cmd_t         cmd = '0;
	epwp_word_t        wr = '0;
	logic              cmd_ready_q, wr_ready_q, done_q, dq_oe_q, oe_n_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] dq_o_q, dq_w;
	logic [LANES-1:0]  cs_n_q, we_n_q;
	int                num_errors = 0, compares = 0, n;
	// A released bus must not look like the last byte written.
	assign dq_w = dq_oe_q ? dq_o_q : ~dq_o_q;
	epwp_host #(.LOCK_CYC(20), .WC_CYC(50), .BLC_CYC(200)) i_epwp_host (
		.clk_sys, .srst, .cmd_valid, .cmd, .cmd_ready_q, .wr_valid, .wr,
		.wr_ready_q, .done_q, .addr_q, .dq_o_q, .dq_oe_q, .cs_n_q, .we_n_q,
		.oe_n_q);
	epwp_dev i_epwp_dev (.clk_sys, .addr(addr_q), .dq(dq_w), .cs_n(cs_n_q),
		.we_n(we_n_q), .oe_n(oe_n_q));
	initial forever #10 clk_sys = ~clk_sys;
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk4(input logic [3:0] got, input logic [3:0] exp);
		chk8({4'h0, got}, {4'h0, exp});
	endtask
	task give_verdict;
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task wait_rdy;
		n = 0;
		while (cmd_ready_q !== 1'b1 && n < 1000) begin
			@(posedge clk_sys);
			n++;
		end
		chk4(4'(n < 1000), 4'h1);
	endtask
	task send_cmd(input epwp_op_t op, input logic [3:0] ln, input logic hd);
		@(posedge clk_sys);
		wait_rdy;
		cmd_valid <= 1'b1;
		cmd <= '{op, ln, hd};
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
	endtask
	task send_word(input logic [16:0] a, input logic [31:0] d, input logic l);
		@(posedge clk_sys);
		n = 0;
		wr_valid <= 1'b1;
		wr <= '{a, d, l};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wr_ready_q !== 1'b1 && n < 2000);
		wr_valid <= 1'b0;
		chk4(4'(n < 2000), 4'h1);
	endtask
	task wait_done;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (done_q !== 1'b1 && n < 1000);
		chk4(4'(n < 1000), 4'h1);
	endtask
	task t_page;
		send_cmd(OP_PLAIN, 4'hf, 1'b1);
		for (int i = 0; i < 128; i++)
			send_word(17'h00080 + 17'(i), {8'(i + 3), 8'(i + 2), 8'(i + 1),
				8'(i)}, i == 127);
		wait_done;
		for (int i = 0; i < 512; i++)
			chk8(i_epwp_dev.mem[i % 4][128 + i / 4],
				8'(i % 4 + i / 4));
		$display("test page done");
	endtask
	task t_on;
		send_cmd(OP_SDP_WR, 4'h1, 1'b1);
		send_word(17'h00100, 32'h44332211, 1'b1);
		wait_done;
		chk4(i_epwp_dev.prot, 4'h1);
		chk8(i_epwp_dev.mem[0][256], 8'h11);
		chk8(i_epwp_dev.mem[1][256], 8'hff);
		$display("test enable done");
	endtask
	task t_guard;
		send_cmd(OP_PLAIN, 4'hf, 1'b1);
		send_word(17'h00101, 32'h88776655, 1'b1);
		wait_done;
		chk8(i_epwp_dev.mem[0][257], 8'hff);
		chk8(i_epwp_dev.mem[1][257], 8'h66);
		$display("test guard done");
	endtask
	task t_unlock;
		send_cmd(OP_SDP_WR, 4'h1, 1'b1);
		send_word(17'h00102, 32'h00000099, 1'b1);
		wait_done;
		chk8(i_epwp_dev.mem[0][258], 8'h99);
		$display("test unlock done");
	endtask
	task t_reset;
		srst <= 1'b1;
		@(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		wait_rdy;
		chk4(4'(n >= 20 && n < 1000), 4'h1);
		chk4(i_epwp_dev.prot, 4'h1);
		$display("test reset done");
	endtask
	task t_off;
		send_cmd(OP_SDP_OFF, 4'h1, 1'b0);
		wait_done;
		chk4(i_epwp_dev.prot, 4'h0);
		send_cmd(OP_PLAIN, 4'h1, 1'b1);
		send_word(17'h00103, 32'h00000077, 1'b1);
		wait_done;
		chk8(i_epwp_dev.mem[0][259], 8'h77);
		$display("test disable done");
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		srst <= 1'b0;
		t_page;
		t_on;
		t_guard;
		t_unlock;
		t_reset;
		t_off;
		chk4(4'(i_epwp_dev.viol), 4'h0);
		give_verdict;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		give_verdict;
	end
endmodule // epwp_host_tb

// ==== verilog/epwp_host.sv ====
/*
 * Host-side controller that loads pages into a four-lane parallel EEPROM
 * and issues the software protection enable and disable sequences.
 * Assumes the device pins are sampled synchronously, the user keeps a word
 * ready within the load window and only this block drives the device bus.
 */
`timescale 1ns/1ps
// Function
// - Host spaces loads under 150 us
// - Host steps only low seven address bits
// - Host holds page address through programming
// - Enable sequence AA, 55, A0
// - Protected writes need the unlock prefix
// - Disable sequence of six command bytes
// - Zero to 128 bytes follow a sequence
module epwp_host import epwp_pkg::*; #(
	parameter int LOCK_CYC = CYC_LOCK,
	parameter int WC_CYC   = CYC_WC,
	parameter int BLC_CYC  = CYC_BLC
) (
	input  wire logic              clk_sys,
	input  wire logic              srst,
	input  wire logic              cmd_valid,
	input  wire epwp_cmd_t         cmd,
	output logic                   cmd_ready_q,
	input  wire logic              wr_valid,
	input  wire epwp_word_t        wr,
	output logic                   wr_ready_q,
	output logic                   done_q,
	output logic [ADDR_W-1:0]      addr_q,
	output logic [DATA_W-1:0]      dq_o_q,
	output logic                   dq_oe_q,
	output logic [LANES-1:0]       cs_n_q,
	output logic [LANES-1:0]       we_n_q,
	output logic                   oe_n_q
);

	localparam logic [TMR_W-1:0] LD_LOCK  = TMR_W'(LOCK_CYC);
	localparam logic [TMR_W-1:0] LD_WP    = TMR_W'(CYC_WP - 1);
	localparam logic [TMR_W-1:0] LD_WPH   = TMR_W'(CYC_WPH - 1);
	localparam logic [TMR_W-1:0] LD_PROG  = TMR_W'(BLC_CYC + WC_CYC);
	localparam logic [TMR_W-1:0] LD_GAP   = TMR_W'(BLC_CYC - CYC_GAP_MARGIN);

	epwp_state_t              state_q, state_d;
	epwp_cmd_t                cmd_q;
	logic [SEQ_W-1:0]         idx_q;
	logic [CNT_W-1:0]         cnt_q;
	logic [ADDR_W-1:PAGE_LSB] page_q;
	logic                     last_q;

	wire cmd_fire = cmd_valid & cmd_ready_q;
	wire wr_fire  = wr_valid & wr_ready_q;

	wire step_exp;
	wire gap_exp;

	wire [SEQ_W-1:0] seq_len = (cmd_q.op == OP_SDP_WR)  ? SEQ_ON_LEN :
	                           (cmd_q.op == OP_SDP_OFF) ? SEQ_OFF_LEN :
	                           SEQ_NONE;
	wire more_cmd  = (idx_q != seq_len);
	wire page_full = (cnt_q == PAGE_BYTES) | last_q;

	// Both sequences open with the same two bytes; only the third differs.
	wire [7:0] seq_byte = (cmd_q.op == OP_SDP_WR && idx_q == SEQ_ON_IDX) ?
	                      SEQ_ON_CODE : SEQ_OFF_DATA[idx_q];

	wire ld_cmd  = (state_q == S_NEXT) & more_cmd;
	wire ld_word = (state_q == S_WAITW) & wr_fire;

	wire [ADDR_W-1:PAGE_LSB] page_sel = (cnt_q == '0) ?
	                                    wr.addr[ADDR_W-1:PAGE_LSB] : page_q;

	wire [ADDR_W-1:0] addr_d = ld_cmd  ? SEQ_ADDR[idx_q] :
	                           ld_word ? {page_sel, wr.addr[PAGE_LSB-1:0]} :
	                           addr_q;
	wire [DATA_W-1:0] dq_d = ld_cmd  ? {LANES{seq_byte}} :
	                         ld_word ? wr.data : dq_o_q;

	wire pins_on = (state_d == S_SETUP) | (state_d == S_PULSE) |
	               (state_d == S_HOLD);
	wire entering = (state_d != state_q);

	wire step_load = entering & ((state_d == S_PULSE) |
	                 (state_d == S_HOLD) | (state_d == S_PROG));
	wire [TMR_W-1:0] step_val = (state_d == S_PULSE) ? LD_WP :
	                            (state_d == S_HOLD)  ? LD_WPH : LD_PROG;
	wire gap_load = (state_q == S_IDLE) | (entering & (state_d == S_PULSE));

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_LOCK:  if (step_exp) begin
				state_d = S_IDLE;
			end
			S_IDLE:  if (cmd_fire) begin
				state_d = S_NEXT;
			end
			S_NEXT: begin
				if (more_cmd) begin
					state_d = S_SETUP;
				end else if (!cmd_q.has_data || page_full) begin
					state_d = S_PROG;
				end else begin
					state_d = S_WAITW;
				end
			end
			S_SETUP: state_d = S_PULSE;
			S_PULSE: if (step_exp) begin
				state_d = S_HOLD;
			end
			S_HOLD:  if (step_exp) begin
				state_d = S_NEXT;
			end
			S_WAITW: begin
				if (wr_fire) begin
					state_d = S_SETUP;
				end else if (gap_exp) begin
					state_d = S_PROG;
				end
			end
			S_PROG:  if (step_exp) begin
				state_d = S_IDLE;
			end
			default: state_d = S_IDLE;
		endcase
	end

	epwp_timer #(.W(TMR_W), .RST_VAL(LD_LOCK)) u_step (
		.clk_sys (clk_sys),
		.srst    (srst),
		.load    (step_load),
		.value   (step_val),
		.expired (step_exp)
	);

	epwp_timer #(.W(TMR_W), .RST_VAL(LD_GAP)) u_gap (
		.clk_sys (clk_sys),
		.srst    (srst),
		.load    (gap_load),
		.value   (LD_GAP),
		.expired (gap_exp)
	);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= S_LOCK;
			cmd_q   <= '0;
			idx_q   <= '0;
			cnt_q   <= '0;
			page_q  <= '0;
			last_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			if (cmd_fire) begin
				cmd_q  <= cmd;
				idx_q  <= '0;
				cnt_q  <= '0;
				last_q <= 1'b0;
			end
			if (ld_cmd) begin
				idx_q <= idx_q + 1'b1;
			end
			if (ld_word) begin
				cnt_q  <= cnt_q + 1'b1;
				page_q <= page_sel;
				last_q <= wr.last;
			end
		end
	end

	// Pins are registered from the next state so they change together.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			addr_q      <= '0;
			dq_o_q      <= '0;
			dq_oe_q     <= 1'b0;
			cs_n_q      <= LANES_OFF;
			we_n_q      <= LANES_OFF;
			oe_n_q      <= 1'b1;
			cmd_ready_q <= 1'b0;
			wr_ready_q  <= 1'b0;
			done_q      <= 1'b0;
		end else begin
			addr_q      <= addr_d;
			dq_o_q      <= dq_d;
			dq_oe_q     <= pins_on;
			cs_n_q      <= pins_on ? ~cmd_q.lanes : LANES_OFF;
			we_n_q      <= (state_d == S_PULSE) ? ~cmd_q.lanes : LANES_OFF;
			oe_n_q      <= 1'b1;
			cmd_ready_q <= (state_d == S_IDLE);
			wr_ready_q  <= (state_d == S_WAITW);
			done_q      <= (state_q == S_PROG) & step_exp;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	wire we_low = (we_n_q != LANES_OFF);
	logic [TMR_W-1:0] gap_cnt_q;
	logic [TMR_W-1:0] lock_cnt_q;

	// Cycles since reset are counted apart from the state machine, so the
	// lockout check does not lean on the timer that it guards.
	wire lock_full = (lock_cnt_q == LD_LOCK);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			gap_cnt_q  <= '0;
			lock_cnt_q <= '0;
		end else begin
			gap_cnt_q  <= ($fell(we_low) || state_q == S_IDLE) ? '0 :
			              gap_cnt_q + 1'b1;
			lock_cnt_q <= lock_full ? lock_cnt_q : lock_cnt_q + 1'b1;
		end
	end

	oe_high_write_a: assert property (we_low |-> oe_n_q)
		else $error("output strobe low during a write pulse");

	pulse_width_a: assert property ($rose(we_low) |-> we_low[*5])
		else $error("write pulse shorter than the least width");

	pulse_high_a: assert property ($fell(we_low) |-> !we_low[*3])
		else $error("write strobe high time too short");

	addr_stable_a: assert property (
		we_low |=> !we_low || ($stable(addr_q) && $stable(dq_o_q)))
		else $error("address or data moved under a write pulse");

	load_gap_a: assert property (
		(state_q == S_WAITW || we_low) |-> gap_cnt_q < TMR_W'(BLC_CYC))
		else $error("byte loads spaced beyond the load window");

	page_fixed_a: assert property (
		$rose(we_low) && cnt_q > 8'h01 && (state_q == S_PULSE) |->
		addr_q[ADDR_W-1:PAGE_LSB] == page_q)
		else $error("page address changed within a page");

	page_count_a: assert property (cnt_q <= PAGE_BYTES)
		else $error("more than one page of loads");

	prog_quiet_a: assert property (
		state_q == S_PROG |-> !we_low && !dq_oe_q && $stable(addr_q))
		else $error("bus activity during programming");

	lockout_a: assert property (
		lock_cnt_q < TMR_W'(LOCK_CYC) |-> !cmd_ready_q && !we_low)
		else $error("request accepted during power-on lockout");

	seq_first_a: assert property (
		ld_cmd && idx_q == SEQ_NONE |=>
		addr_q == SEQ_ADDR[0] && dq_o_q[7:0] == SEQ_OFF_DATA[0])
		else $error("command sequence does not open correctly");

	seq_third_a: assert property (
		ld_cmd && idx_q == SEQ_ON_IDX && cmd_q.op == OP_SDP_OFF |=>
		dq_o_q[7:0] == SEQ_OFF_DATA[2])
		else $error("disable sequence third byte wrong");

	cov_plain_c:  cover property (cmd_fire && cmd.op == OP_PLAIN);
	cov_sdp_on_c: cover property (ld_cmd && cmd_q.op == OP_SDP_WR
		&& idx_q == SEQ_ON_IDX);
	cov_sdp_off_c: cover property (state_q == S_NEXT
		&& cmd_q.op == OP_SDP_OFF && !more_cmd && !cmd_q.has_data);
	cov_gap_close_c: cover property (state_q == S_WAITW && gap_exp
		&& !wr_fire);

endmodule // epwp_host

// ==== verilog/epwp_timer.sv ====
/*
 * Loadable down-counter used for strobe widths, the byte load gap and the
 * long waits of the write controller.
 * Assumes a synchronous active-high reset on the same clock.
 */
`timescale 1ns/1ps
module epwp_timer #(
	parameter int               W       = 20,
	parameter logic [W-1:0]     RST_VAL = '0
) (
	input  wire logic         clk_sys,
	input  wire logic         srst,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              expired
);

	logic [W-1:0] count_q;

	assign expired = (count_q == '0);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			count_q <= RST_VAL;
		end else if (load) begin
			count_q <= value;
		end else if (!expired) begin
			count_q <= count_q - 1'b1;
		end
	end

endmodule // epwp_timer
